// ===== design/desc_pkg.sv
// Purpose: Shared constants for the transfer descriptor slot
// Assumes: 32-bit register port, byte addresses on word boundaries
// Notes: Descriptor words sit at the bottom of the map
package desc_pkg;

  // ==========================================================
  // Sizes
  localparam int DW_W = 32;
  localparam int DESC_WORDS = 8;
  localparam int WORD_IDX_W = 3;
  localparam int ADDR_W = 8;
  localparam int EV_W = 5;
  localparam int FRAME_W = 11;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_DESC_LAST = 8'h1c;
  localparam logic [7:0] OFF_CTRL = 8'h20;
  localparam logic [7:0] OFF_STATE = 8'h24;
  localparam logic [7:0] OFF_INT_STATUS = 8'h28;
  localparam logic [7:0] OFF_INT_CLEAR = 8'h2c;
  localparam logic [7:0] OFF_INT_ENABLE = 8'h30;
  localparam logic [7:0] OFF_FRAME_TARGET = 8'h34;

  // ==========================================================
  // Reset values
  localparam logic [4:0] INT_ENABLE_RST = 5'h00;
  localparam logic [10:0] FRAME_TARGET_RST = 11'h000;

  // ==========================================================
  // Control register bits
  localparam int CTRL_GO_BIT = 0;

  // ==========================================================
  // Word indices
  localparam logic [2:0] W_HDR = 3'h0;
  localparam logic [2:0] W_ROUTE = 3'h1;
  localparam logic [2:0] W_START = 3'h2;
  localparam logic [2:0] W_RESULT = 3'h3;
  localparam logic [2:0] W_UFRAME = 3'h4;
  localparam logic [2:0] W_CNT_FIRST = 3'h5;
  localparam logic [2:0] W_LAST = 3'h7;

  // ==========================================================
  // Header word fields
  localparam int V_BIT = 0;
  localparam int TOTAL_LSB = 3;
  localparam int TOTAL_W = 15;
  localparam int MPS_LSB = 18;
  localparam int MPS_W = 11;
  localparam int MULT_LSB = 29;
  localparam int MULT_W = 2;
  localparam int EPT0_BIT = 31;

  // Route word fields
  localparam int EPT_HI_LSB = 0;
  localparam int EPT_HI_W = 3;
  localparam int FADDR_LSB = 3;
  localparam int FADDR_W = 7;
  localparam int TOKEN_LSB = 10;
  localparam int TYPE_LSB = 12;
  localparam int SPLIT_BIT = 14;

  // Start word fields
  localparam int START_LSB = 8;
  localparam int START_W = 16;

  // Result word fields
  localparam int DONE_LSB = 0;
  localparam int HALT_BIT = 30;

  // Microframe word fields
  localparam int MASK_LSB = 0;
  localparam int MASK_W = 8;
  localparam int USTAT_LSB = 8;
  localparam int USTAT_W = 3;
  localparam int UCOUNT_W = 12;

  // ==========================================================
  // Codes
  localparam logic [1:0] TOKEN_OUT = 2'h0;
  localparam logic [1:0] TOKEN_IN = 2'h1;
  localparam logic [1:0] TOKEN_SETUP = 2'h2;
  localparam logic [1:0] TOKEN_PING = 2'h3;
  localparam logic [1:0] TYPE_ISO = 2'h1;
  localparam logic [1:0] TYPE_BULK = 2'h2;
  localparam logic [10:0] BULK_MPS_MAX = 11'h200;

  // Event bits
  localparam int EV_DONE = 0;
  localparam int EV_FATAL = 1;
  localparam int EV_UFRAME = 2;
  localparam int EV_SKIP = 3;
  localparam int EV_PARAM = 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_CHECK = 3'b011,
    ST_RUN = 3'b010,
    ST_WB = 3'b110
  } slot_state_e;

endpackage

// ===== design/desc_word_ram.sv
// Purpose: Two-port word memory holding one descriptor
// Assumes: Port b wins when both ports write one word
// Notes: Read data come from a register, one cycle after the address
`timescale 1ns/1ps
module desc_word_ram #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Software port
  input wire logic [AW-1:0] a_addr,
  input wire logic a_wr,
  input wire logic [WIDTH-1:0] a_wdata,
  output logic [WIDTH-1:0] a_rdata,
  // Controller port
  input wire logic [AW-1:0] b_addr,
  input wire logic b_wr,
  input wire logic [WIDTH-1:0] b_wdata,
  output logic [WIDTH-1:0] b_rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock)
  begin
    if (b_wr)
    begin
      mem[b_addr] <= b_wdata;
    end
    if (a_wr && !(b_wr && (a_addr == b_addr)))
    begin
      mem[a_addr] <= a_wdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      a_rdata <= '0;
      b_rdata <= '0;
    end
    else
    begin
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
    end
  end

endmodule

// ===== design/transfer_descriptor_slot.sv
// Purpose: Holds one transfer descriptor, hands it to the transaction engine, writes results back
// Assumes: Engine runs on the same clock and only reports while engine_ready is high
// Notes: Software writes the descriptor words, then sets go
//
// Behaviour
// - The header word holds an 11-bit largest packet size in bits 28 to 18.
// - An isochronous descriptor accepts any whole-number packet size.
// - Bits 17 to 3 give the payload total, from one byte up to 20 kB.
// - The valid bit 0 is cleared when execution finishes or a fatal error occurs.
// - The isochronous descriptor spans eight words and reuses the bulk header fields.
// - The route word carries split, 2-bit type, 2-bit token, 7-bit address and upper endpoint bits.
// - One word holds eight 3-bit microframe results above an 8-bit microframe mask.
// - Eight 12-bit received counts fill the top three words, the third and sixth split across word edges.
// - A microframe count is written only with its mask bit set and a matching frame number.
// - Token codes are OUT 00, IN 01, SETUP 10; only the controller makes PING 11; the slot passes a software-written 11 to token_code unchecked.
`timescale 1ns/1ps
module transfer_descriptor_slot #(
  parameter int FRAME_BITS = desc_pkg::FRAME_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [desc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [desc_pkg::DW_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [desc_pkg::DW_W-1:0] reg_rdata,
  // Interrupt
  output logic irq,
  // Engine request
  output logic xfer_start,
  output logic engine_ready,
  output logic iso_mode,
  output logic split_txn,
  output logic [1:0] endpoint_transfer_type,
  output logic [1:0] token_code,
  output logic [6:0] target_function_addr,
  output logic [3:0] endpoint_number,
  output logic [1:0] packet_mult,
  output logic [10:0] max_packet_bytes,
  output logic [14:0] transfer_byte_total,
  output logic [15:0] payload_ram_start,
  output logic [7:0] microframe_active_mask,
  // Engine results
  input wire logic xfer_done,
  input wire logic [14:0] bytes_done_count,
  input wire logic xfer_fatal,
  input wire logic uframe_done,
  input wire logic [2:0] uframe_index,
  input wire logic [2:0] uframe_result_code,
  input wire logic [11:0] uframe_rx_bytes,
  input wire logic [FRAME_BITS-1:0] uframe_frame
);

  // ==========================================================
  // Declarations
  desc_pkg::slot_state_e state_reg, state_next;
  logic [2:0] idx_reg, idx_next;
  logic cap_reg, cap_next;
  logic [2:0] cap_idx_reg, cap_idx_next;
  logic final_reg, final_next;
  logic start_reg, start_next;
  logic [31:0] desc_reg [8];
  logic [31:0] desc_next [8];
  logic [4:0] int_status_reg, int_status_next;
  logic [4:0] int_enable_reg, int_enable_next;
  logic [FRAME_BITS-1:0] frame_target_reg, frame_target_next;
  logic rd_mem_reg, rd_mem_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [2:0] b_addr;
  logic b_wr;
  logic [31:0] b_wdata;
  logic [31:0] a_rdata;
  logic [31:0] b_rdata;
  logic desc_hit;
  logic go_write;
  logic [4:0] events;
  logic [95:0] counts;
  logic [31:0] hdr;
  logic [31:0] route;

  // ==========================================================
  // Descriptor memory
  assign desc_hit = (reg_addr <= desc_pkg::OFF_DESC_LAST) && (reg_addr[1:0] == 2'h0);

  desc_word_ram #(
    .WIDTH(desc_pkg::DW_W),
    .DEPTH(desc_pkg::DESC_WORDS),
    .AW(desc_pkg::WORD_IDX_W)
  ) u_ram (
    .clock(clock),
    .rst_n(rst_n),
    .a_addr(reg_addr[4:2]),
    .a_wr(reg_wr && desc_hit),
    .a_wdata(reg_wdata),
    .a_rdata(a_rdata),
    .b_addr(b_addr),
    .b_wr(b_wr),
    .b_wdata(b_wdata),
    .b_rdata(b_rdata)
  );

  // ==========================================================
  // Field views
  assign hdr = desc_reg[desc_pkg::W_HDR];
  assign route = desc_reg[desc_pkg::W_ROUTE];
  assign max_packet_bytes = hdr[desc_pkg::MPS_LSB +: desc_pkg::MPS_W];
  assign transfer_byte_total = hdr[desc_pkg::TOTAL_LSB +: desc_pkg::TOTAL_W];
  assign packet_mult = hdr[desc_pkg::MULT_LSB +: desc_pkg::MULT_W];
  assign endpoint_number = {route[desc_pkg::EPT_HI_LSB +: desc_pkg::EPT_HI_W], hdr[desc_pkg::EPT0_BIT]};
  assign target_function_addr = route[desc_pkg::FADDR_LSB +: desc_pkg::FADDR_W];
  assign token_code = route[desc_pkg::TOKEN_LSB +: 2];
  assign endpoint_transfer_type = route[desc_pkg::TYPE_LSB +: 2];
  assign split_txn = route[desc_pkg::SPLIT_BIT];
  assign payload_ram_start = desc_reg[desc_pkg::W_START][desc_pkg::START_LSB +: desc_pkg::START_W];
  assign microframe_active_mask = desc_reg[desc_pkg::W_UFRAME][desc_pkg::MASK_LSB +: desc_pkg::MASK_W];
  assign iso_mode = (endpoint_transfer_type == desc_pkg::TYPE_ISO);
  assign xfer_start = start_reg;
  assign engine_ready = (state_reg == desc_pkg::ST_RUN);
  assign irq = |(int_status_reg & int_enable_reg);
  assign reg_rdata = rd_mem_reg ? a_rdata : rdata_reg;

  // ==========================================================
  // Sequencer next state
  always_comb
  begin
    state_next = state_reg;
    idx_next = idx_reg;
    cap_next = 1'b0;
    cap_idx_next = idx_reg;
    final_next = final_reg;
    start_next = 1'b0;
    events = '0;
    b_addr = idx_reg;
    b_wr = 1'b0;
    b_wdata = desc_reg[idx_reg];
    counts = {desc_reg[7], desc_reg[6], desc_reg[5]};
    for (int i = 0; i < desc_pkg::DESC_WORDS; i++)
    begin
      desc_next[i] = desc_reg[i];
    end
    if (cap_reg)
    begin
      desc_next[cap_idx_reg] = b_rdata;
    end
    go_write = reg_wr && (reg_addr == desc_pkg::OFF_CTRL) && reg_wdata[desc_pkg::CTRL_GO_BIT];
    case (state_reg)
      desc_pkg::ST_IDLE:
      begin
        if (go_write)
        begin
          state_next = desc_pkg::ST_FETCH;
          idx_next = desc_pkg::W_HDR;
        end
      end
      desc_pkg::ST_FETCH:
      begin
        cap_next = 1'b1;
        idx_next = idx_reg + 3'h1;
        if (idx_reg == desc_pkg::W_LAST)
        begin
          state_next = desc_pkg::ST_CHECK;
        end
      end
      desc_pkg::ST_CHECK:
      begin
        if (!hdr[desc_pkg::V_BIT])
        begin
          // Leave the memory untouched
          state_next = desc_pkg::ST_IDLE;
          events[desc_pkg::EV_SKIP] = 1'b1;
        end
        else if ((endpoint_transfer_type == desc_pkg::TYPE_BULK) && (max_packet_bytes > desc_pkg::BULK_MPS_MAX))
        begin
          // Oversized bulk packet refused; iso sizes pass unchecked
          state_next = desc_pkg::ST_IDLE;
          events[desc_pkg::EV_PARAM] = 1'b1;
        end
        else
        begin
          state_next = desc_pkg::ST_RUN;
          start_next = 1'b1;
        end
      end
      desc_pkg::ST_RUN:
      begin
        if (xfer_fatal)
        begin
          desc_next[desc_pkg::W_HDR][desc_pkg::V_BIT] = 1'b0;
          desc_next[desc_pkg::W_RESULT][desc_pkg::HALT_BIT] = 1'b1;
          events[desc_pkg::EV_FATAL] = 1'b1;
          final_next = 1'b1;
          idx_next = desc_pkg::W_HDR;
          state_next = desc_pkg::ST_WB;
        end
        else if (xfer_done)
        begin
          desc_next[desc_pkg::W_HDR][desc_pkg::V_BIT] = 1'b0;
          desc_next[desc_pkg::W_RESULT][desc_pkg::DONE_LSB +: desc_pkg::TOTAL_W] = bytes_done_count;
          events[desc_pkg::EV_DONE] = 1'b1;
          final_next = 1'b1;
          idx_next = desc_pkg::W_HDR;
          state_next = desc_pkg::ST_WB;
        end
        else if (uframe_done && iso_mode)
        begin
          events[desc_pkg::EV_UFRAME] = 1'b1;
          if (microframe_active_mask[uframe_index] && (uframe_frame == frame_target_reg))
          begin
            counts[32'(uframe_index) * desc_pkg::UCOUNT_W +: desc_pkg::UCOUNT_W] = uframe_rx_bytes;
            desc_next[5] = counts[31:0];
            desc_next[6] = counts[63:32];
            desc_next[7] = counts[95:64];
            desc_next[desc_pkg::W_UFRAME][desc_pkg::USTAT_LSB + 32'(uframe_index) * desc_pkg::USTAT_W +:
              desc_pkg::USTAT_W] = uframe_result_code;
            final_next = 1'b0;
            idx_next = desc_pkg::W_UFRAME;
            state_next = desc_pkg::ST_WB;
          end
        end
      end
      desc_pkg::ST_WB:
      begin
        b_wr = 1'b1;
        idx_next = idx_reg + 3'h1;
        if (idx_reg == desc_pkg::W_LAST)
        begin
          state_next = final_reg ? desc_pkg::ST_IDLE : desc_pkg::ST_RUN;
        end
      end
      default:
      begin
        state_next = desc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_reg <= desc_pkg::ST_IDLE;
      idx_reg <= 3'h0;
      cap_reg <= 1'b0;
      cap_idx_reg <= 3'h0;
      final_reg <= 1'b0;
      start_reg <= 1'b0;
      for (int i = 0; i < desc_pkg::DESC_WORDS; i++)
      begin
        desc_reg[i] <= '0;
      end
    end
    else
    begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      cap_reg <= cap_next;
      cap_idx_reg <= cap_idx_next;
      final_reg <= final_next;
      start_reg <= start_next;
      for (int i = 0; i < desc_pkg::DESC_WORDS; i++)
      begin
        desc_reg[i] <= desc_next[i];
      end
    end
  end

  // ==========================================================
  // Register file next state
  always_comb
  begin
    int_enable_next = int_enable_reg;
    frame_target_next = frame_target_reg;
    int_status_next = int_status_reg;
    if (reg_wr && (reg_addr == desc_pkg::OFF_INT_CLEAR))
    begin
      int_status_next = int_status_reg & ~reg_wdata[desc_pkg::EV_W-1:0];
    end
    // New events win over a clear in the same cycle
    int_status_next = int_status_next | events;
    if (reg_wr && (reg_addr == desc_pkg::OFF_INT_ENABLE))
    begin
      int_enable_next = reg_wdata[desc_pkg::EV_W-1:0];
    end
    if (reg_wr && (reg_addr == desc_pkg::OFF_FRAME_TARGET))
    begin
      frame_target_next = reg_wdata[FRAME_BITS-1:0];
    end
    rd_mem_next = reg_rd && desc_hit;
    rdata_next = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        desc_pkg::OFF_CTRL:
        begin
          rdata_next = {31'h0000_0000, state_reg != desc_pkg::ST_IDLE};
        end
        desc_pkg::OFF_STATE:
        begin
          rdata_next = {26'h000_0000, idx_reg, 3'(state_reg)};
        end
        desc_pkg::OFF_INT_STATUS:
        begin
          rdata_next = {27'h000_0000, int_status_reg};
        end
        desc_pkg::OFF_INT_ENABLE:
        begin
          rdata_next = {27'h000_0000, int_enable_reg};
        end
        desc_pkg::OFF_FRAME_TARGET:
        begin
          rdata_next = 32'(frame_target_reg);
        end
        default:
        begin
          rdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      int_status_reg <= '0;
      int_enable_reg <= desc_pkg::INT_ENABLE_RST;
      frame_target_reg <= FRAME_BITS'(desc_pkg::FRAME_TARGET_RST);
      rd_mem_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      int_status_reg <= int_status_next;
      int_enable_reg <= int_enable_next;
      frame_target_reg <= frame_target_next;
      rd_mem_reg <= rd_mem_next;
      rdata_reg <= rdata_next;
    end
  end

endmodule

// ===== tb/slot_props.sv
// Purpose: Port assertions for the descriptor slot
// Assumes: One clock, synchronous active-low reset
// Notes: Bound into the slot at the foot
`timescale 1ns/1ps
module slot_props (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Engine side
  input wire logic xfer_start,
  input wire logic engine_ready,
  input wire logic iso_mode,
  input wire logic [1:0] endpoint_transfer_type,
  input wire logic [10:0] max_packet_bytes,
  input wire logic [14:0] transfer_byte_total,
  input wire logic [15:0] payload_ram_start,
  input wire logic [7:0] microframe_active_mask,
  input wire logic xfer_done,
  input wire logic xfer_fatal,
  input wire logic uframe_done,
  input wire logic [2:0] uframe_index
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // ==========================
  // Properties
  property p_start_ready;
    xfer_start |-> engine_ready && !$past(engine_ready);
  endproperty
  property p_start_once;
    engine_ready |=> !xfer_start;
  endproperty
  property p_iso_type;
    engine_ready && !iso_mode && !xfer_done && !xfer_fatal |=> engine_ready;
  endproperty
  property p_bulk_cap;
    xfer_start && endpoint_transfer_type == desc_pkg::TYPE_BULK |-> max_packet_bytes <= desc_pkg::BULK_MPS_MAX;
  endproperty
  property p_done_ends;
    engine_ready && xfer_done |=> !engine_ready [*8];
  endproperty
  property p_fatal_ends;
    engine_ready && xfer_fatal |=> (!engine_ready && !xfer_start) [*8];
  endproperty
  property p_fields_hold;
    engine_ready ##1 engine_ready |-> $stable({max_packet_bytes, transfer_byte_total, payload_ram_start});
  endproperty
  property p_masked;
    engine_ready && iso_mode && uframe_done && !xfer_done && !xfer_fatal
      && !microframe_active_mask[uframe_index] |=> engine_ready;
  endproperty
  a_start_ready: assert property (p_start_ready) else $error("start without fresh ready");
  a_start_once: assert property (p_start_once) else $error("start while running");
  a_iso_type: assert property (p_iso_type) else $error("bulk run left early");
  a_bulk_cap: assert property (p_bulk_cap) else $error("bulk packet size above cap");
  a_done_ends: assert property (p_done_ends) else $error("ready after done");
  a_fatal_ends: assert property (p_fatal_ends) else $error("ready after fatal");
  a_fields_hold: assert property (p_fields_hold) else $error("fields moved while running");
  a_masked: assert property (p_masked) else $error("masked microframe left run");
  c_done: cover property (engine_ready && xfer_done);
  c_fatal: cover property (engine_ready && xfer_fatal);
  c_masked: cover property (engine_ready && uframe_done && !microframe_active_mask[uframe_index]);
endmodule
bind transfer_descriptor_slot slot_props u_props (
  .clock(clock), .rst_n(rst_n), .xfer_start(xfer_start), .engine_ready(engine_ready), .iso_mode(iso_mode),
  .endpoint_transfer_type(endpoint_transfer_type), .max_packet_bytes(max_packet_bytes),
  .transfer_byte_total(transfer_byte_total), .payload_ram_start(payload_ram_start),
  .microframe_active_mask(microframe_active_mask), .xfer_done(xfer_done), .xfer_fatal(xfer_fatal),
  .uframe_done(uframe_done), .uframe_index(uframe_index)
);

// ===== tb/engine_model.sv
// Purpose: Transaction engine stand-in reporting results to the slot
// Assumes: Waits up to 200 cycles for engine_ready to be high, then reports even if it never rose
// Notes: Result lines carry inverted data between pulses
`timescale 1ns/1ps
module engine_model (
  // Clock
  input wire logic clock,
  // Handshake
  input wire logic engine_ready,
  // Results
  output logic xfer_done,
  output logic [14:0] bytes_done_count,
  output logic xfer_fatal,
  output logic uframe_done,
  output logic [2:0] uframe_index,
  output logic [2:0] uframe_result_code,
  output logic [11:0] uframe_rx_bytes,
  output logic [10:0] uframe_frame
);
  initial
  begin
    {xfer_done, xfer_fatal, uframe_done} = 3'b000;
    {bytes_done_count, uframe_index, uframe_result_code, uframe_rx_bytes, uframe_frame} = '1;
  end
  // Kind 0 done, 1 fatal, 2 microframe, 3 done with fatal
  task automatic report(input logic [1:0] kind, input int gap, input logic [14:0] n, input logic [2:0] idx,
    input logic [2:0] code, input logic [11:0] rx, input logic [10:0] frame, output bit ok);
    int i;
    begin
      for (i = 0; i < gap; i++)
        @(posedge clock);
      i = 0;
      @(negedge clock);
      while (engine_ready !== 1'b1 && i < 200)
      begin
        @(negedge clock);
        i++;
      end
      ok = (i < 200);
      @(posedge clock);
      xfer_done <= (kind == 2'd0) || (kind == 2'd3);
      xfer_fatal <= kind[0];
      uframe_done <= (kind == 2'd2);
      {bytes_done_count, uframe_index, uframe_result_code, uframe_rx_bytes, uframe_frame} <= {n, idx, code, rx, frame};
      @(posedge clock);
      {xfer_done, xfer_fatal, uframe_done} <= 3'b000;
      {bytes_done_count, uframe_index, uframe_result_code, uframe_rx_bytes, uframe_frame} <= ~{n, idx, code, rx, frame};
    end
  endtask
endmodule

// ===== tb/transfer_descriptor_slot_tb_top.sv
// Purpose: Self-checking bench for the descriptor slot
// Assumes: Engine stand-in answers through its report task
// Notes: Bulk, fatal, skip, refusal and isochronous passes
`timescale 1ns/1ps
module transfer_descriptor_slot_tb_top;
  // ==========================
  // Signals
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, rv;
  logic irq, xfer_start, engine_ready, iso_mode, split_txn, xfer_done, xfer_fatal, uframe_done;
  logic [1:0] endpoint_transfer_type, token_code, packet_mult;
  logic [6:0] target_function_addr;
  logic [3:0] endpoint_number;
  logic [10:0] max_packet_bytes, uframe_frame;
  logic [14:0] transfer_byte_total, bytes_done_count;
  logic [15:0] payload_ram_start;
  logic [7:0] microframe_active_mask;
  logic [2:0] uframe_index, uframe_result_code;
  logic [11:0] uframe_rx_bytes;
  int miscompares = 0;
  int checks_done = 0;
  int starts = 0;
  always #4 clock = ~clock;
  always @(posedge clock) if (xfer_start === 1'b1) starts <= starts + 1;
  transfer_descriptor_slot u_dut (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .xfer_start(xfer_start), .engine_ready(engine_ready), .iso_mode(iso_mode),
    .split_txn(split_txn), .endpoint_transfer_type(endpoint_transfer_type), .token_code(token_code),
    .target_function_addr(target_function_addr), .endpoint_number(endpoint_number), .packet_mult(packet_mult),
    .max_packet_bytes(max_packet_bytes), .transfer_byte_total(transfer_byte_total),
    .payload_ram_start(payload_ram_start), .microframe_active_mask(microframe_active_mask),
    .xfer_done(xfer_done), .bytes_done_count(bytes_done_count), .xfer_fatal(xfer_fatal),
    .uframe_done(uframe_done), .uframe_index(uframe_index), .uframe_result_code(uframe_result_code),
    .uframe_rx_bytes(uframe_rx_bytes), .uframe_frame(uframe_frame)
  );
  engine_model u_eng (
    .clock(clock), .engine_ready(engine_ready), .xfer_done(xfer_done), .bytes_done_count(bytes_done_count),
    .xfer_fatal(xfer_fatal), .uframe_done(uframe_done), .uframe_index(uframe_index),
    .uframe_result_code(uframe_result_code), .uframe_rx_bytes(uframe_rx_bytes), .uframe_frame(uframe_frame)
  );
  // ==========================
  // Helpers
  task automatic report_and_stop;
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    rv = reg_rdata;
    if (what != "")
      check(what, rv & m, exp);
    @(posedge clock);
  endtask
  task automatic chk_irq(input logic exp);
    @(negedge clock);
    check("irq", irq, exp);
    @(posedge clock);
  endtask
  task automatic irq_sweep(input logic [31:0] m);
    wr(8'h30, m);
    chk_irq(1'b1);
    wr(8'h2c, m);
    chk_irq(1'b0);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 50; i++)
    begin
      rd_chk("", 8'h20, 32'h0, 32'h0);
      if (rv[0] === 1'b0)
        return;
    end
    miscompares++;
    report_and_stop;
  endtask
  task automatic eng(input logic [1:0] kind, input int gap, input logic [14:0] n, input logic [2:0] idx,
    input logic [2:0] code, input logic [11:0] rx, input logic [10:0] frame);
    bit ok;
    u_eng.report(kind, gap, n, idx, code, rx, frame, ok);
    if (!ok)
    begin
      miscompares++;
      report_and_stop;
    end
  endtask
  task automatic load_go(input logic v, input logic [1:0] typ, input logic [1:0] tok, input logic [10:0] mps,
    input logic [14:0] tot, input logic [7:0] mask);
    wr(8'h00, {1'b1, 2'b01, mps, tot, 2'b00, v});
    wr(8'h04, {17'h0_0000, 1'b1, typ, tok, 7'h2a, 3'h4});
    wr(8'h08, 32'h0012_3400);
    wr(8'h0c, 32'h0000_5555);
    wr(8'h10, {24'h00_0000, mask});
    for (int i = 5; i < 8; i++)
      wr(8'(4 * i), 32'h0000_0000);
    wr(8'h20, 32'h0000_0001);
  endtask
  // ==========================
  // Scenarios
  task automatic regs_after_reset;
    rd_chk("enable", 8'h30, 32'h0000_001f, 32'h0000_0000);
    rd_chk("frame", 8'h34, 32'h0000_07ff, 32'h0000_0000);
    rd_chk("state", 8'h24, 32'h3f, 32'h0);
    rd_chk("status", 8'h28, 32'h0000_001f, 32'h0000_0000);
    wr(8'h40, 32'hffff_ffff);
    rd_chk("unmapped", 8'h40, 32'hffff_ffff, 32'h0000_0000);
    chk_irq(1'b0);
  endtask
  task automatic bulk_runs;
    logic [14:0] tot;
    for (int k = 0; k < 3; k++)
    begin
      tot = (k == 1) ? 15'h0001 : 15'h5000;
      load_go(1'b1, desc_pkg::TYPE_BULK, 2'(k), 11'h200 - 11'(k), tot, 8'h00);
      eng(2'd0, k * 20, 15'h0100 + 15'(k), 3'h0, 3'h0, 12'h000, 11'h000);
      wait_idle;
      check("sizes", {max_packet_bytes, transfer_byte_total}, {11'h200 - 11'(k), tot});
      check("route", {split_txn, endpoint_transfer_type, token_code, target_function_addr, endpoint_number,
        packet_mult}, {1'b1, desc_pkg::TYPE_BULK, 2'(k), 7'h2a, 4'h9, 2'b01});
      check("start", payload_ram_start, 16'h1234);
      rd_chk("valid", 8'h00, 32'hffff_ffff, {1'b1, 2'b01, 11'h200 - 11'(k), tot, 3'b000});
      rd_chk("count", 8'h0c, 32'h4000_7fff, 32'h0000_0100 + k);
      rd_chk("status", 8'h28, 32'h0000_001f, 32'h0000_0001);
      irq_sweep(32'h0000_0001);
    end
    check("starts", starts, 3);
  endtask
  task automatic fatal_run;
    load_go(1'b1, desc_pkg::TYPE_BULK, desc_pkg::TOKEN_IN, 11'h040, 15'h0064, 8'h00);
    eng(2'd3, 3, 15'h0010, 3'h0, 3'h0, 12'h000, 11'h000);
    wait_idle;
    rd_chk("valid", 8'h00, 32'h0000_0001, 32'h0000_0000);
    rd_chk("halt", 8'h0c, 32'h4000_0000, 32'h4000_0000);
    rd_chk("status", 8'h28, 32'h0000_001f, 32'h0000_0002);
    chk_irq(1'b0);
    irq_sweep(32'h0000_0002);
  endtask
  task automatic skip_refuse;
    load_go(1'b0, desc_pkg::TYPE_BULK, desc_pkg::TOKEN_OUT, 11'h040, 15'h0010, 8'h00);
    wait_idle;
    rd_chk("untouched", 8'h0c, 32'hffff_ffff, 32'h0000_5555);
    rd_chk("status", 8'h28, 32'h0000_001f, 32'h0000_0008);
    wr(8'h2c, 32'h0000_001f);
    load_go(1'b1, desc_pkg::TYPE_BULK, desc_pkg::TOKEN_OUT, 11'h201, 15'h0010, 8'h00);
    wait_idle;
    rd_chk("status", 8'h28, 32'h0000_001f, 32'h0000_0010);
    check("starts", starts, 4);
  endtask
  task automatic iso_run;
    wr(8'h34, 32'h0000_0005);
    wr(8'h2c, 32'h0000_001f);
    load_go(1'b1, desc_pkg::TYPE_ISO, desc_pkg::TOKEN_IN, 11'h309, 15'h0400, 8'h04);
    eng(2'd2, 0, 15'h0000, 3'h2, 3'h5, 12'habc, 11'h005);
    eng(2'd2, 2, 15'h0000, 3'h3, 3'h6, 12'h123, 11'h005);
    eng(2'd2, 0, 15'h0000, 3'h2, 3'h7, 12'h456, 11'h006);
    eng(2'd0, 1, 15'h0400, 3'h0, 3'h0, 12'h000, 11'h000);
    wait_idle;
    check("iso", {iso_mode, max_packet_bytes, microframe_active_mask}, {1'b1, 11'h309, 8'h04});
    rd_chk("uframe word", 8'h10, 32'hffff_ffff, 32'h0001_4004);
    rd_chk("count word5", 8'h14, 32'hffff_ffff, 32'hbc00_0000);
    rd_chk("count word6", 8'h18, 32'hffff_ffff, 32'h0000_000a);
    rd_chk("count word7", 8'h1c, 32'hffff_ffff, 32'h0000_0000);
    rd_chk("status", 8'h28, 32'h0000_001f, 32'h0000_0005);
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    regs_after_reset;
    bulk_runs;
    fatal_run;
    skip_refuse;
    iso_run;
    report_and_stop;
  end
endmodule
